/* File: design/ehc_comparator.sv */
// How it works
// - One shared next-protocol set beside flows, except in the OAM engine.
// - Last EtherType after tags names next protocol.
// - Three-bit pointer picks the next stage.
// - Five-bit offset marks the signature start.
// - Global TPID recognises S and B tags.
// - Backbone bridging only in first stage.
// - Optional EtherType compare for type II frames.
// - Per-flow enable and per-channel use bit.
// - Per-flow expected tag count: zero, one, two.
// - First tag type chooses C, S, B or I.
// - Second tag type; always I-tag when bridging.
// - Type/length mode controls LLC/SNAP acceptance.
// - Verify bit enables tag count and values.
// - Range mode picks tag one, two or none.
// - Address compared against DA, SA or either.
// - Address modes: full, unicast, multicast, combined.
// - Tag match and wildcard; unused wildcard zero.
// - Range limits, or I-tag service identifier halves.
// - Two next-protocol sets in the OAM engine, flow picks one.
// - Wildcard bit zero ignores that position.
// - Range limits are inclusive on both ends.
// - Next-stage identifiers run from zero to five.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none

module ehc_comparator #(
  parameter int FLOWS       = 8,
  parameter int HDR_BYTES   = 32,
  parameter bit FIRST_STAGE = 1'b1,
  parameter bit OAM_ENGINE  = 1'b0
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic [ehc_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [ehc_pkg::DATA_W-1:0]    reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [ehc_pkg::DATA_W-1:0]    reg_rdata_o,
  input  wire logic                          frm_valid_i,
  input  wire ehc_pkg::ehc_byte_s            frm_i,
  output logic                               res_valid_o,
  output ehc_pkg::ehc_result_s               res_o
);

  localparam int CNT_W = $clog2(HDR_BYTES + 1);

  ehc_pkg::ehc_state_e    state_ff;
  logic [CNT_W-1:0]       cnt_ff;
  logic [2:0]             chan_ff;
  logic [7:0]             hdr_ff [HDR_BYTES];
  ehc_pkg::ehc_np_cfg_s   np_ff [ehc_pkg::NP_SETS];
  ehc_pkg::ehc_global_s   global_ff;
  ehc_pkg::ehc_flow_cfg_s flow_ff [FLOWS];
  logic                   res_valid_ff;
  ehc_pkg::ehc_result_s   res_ff;
  logic [ehc_pkg::DATA_W-1:0] rdata_ff;

  logic                   start_w;
  logic                   cap_en;
  logic [CNT_W-1:0]       wr_idx;
  logic                   last_byte;
  logic                   pbb_on;
  ehc_pkg::ehc_hdr_s      hdr;
  logic [15:0]            w_t0;
  logic [15:0]            w_t1tci;
  logic [15:0]            w_t1w;
  logic [15:0]            w_t2tci;
  logic [15:0]            w_tl;
  int unsigned            i_off;
  int unsigned            e_off;
  logic [ehc_pkg::NP_SETS-1:0]   np_ok;
  logic [ehc_pkg::FLOWS_MAX-1:0] flow_hit;
  logic [ehc_pkg::FLOWS_MAX-1:0] flow_set;
  logic                   sel_set;
  logic                   flow_page;
  logic [2:0]             flow_idx;
  logic [4:0]             flow_sub;
  logic [ehc_pkg::DATA_W-1:0] rd_val;
  ehc_pkg::ehc_np_ctrl_s  np_ctrl_w;

  function automatic logic [15:0] wrd(input int unsigned i);
    wrd = {hdr_ff[i], hdr_ff[i + 1]};
  endfunction

  function automatic logic is_tag(input logic [15:0] w, input logic [15:0] tpid);
    is_tag = (w == ehc_pkg::C_TAG_TPID) || (w == tpid);
  endfunction

  assign pbb_on    = FIRST_STAGE && global_ff.pbb_en;
  assign flow_page = reg_addr_i[ehc_pkg::ADDR_W-1:8] == ehc_pkg::FLOW_PAGE;
  assign flow_idx  = reg_addr_i[7:5];
  assign flow_sub  = reg_addr_i[4:0];
  assign np_ctrl_w = ehc_pkg::ehc_np_ctrl_s'(reg_wdata_i & ehc_pkg::NP_CTRL_WMASK);

  // Register file: next-protocol sets, set B only exists in the OAM engine.
  for (genvar s = 0; s < ehc_pkg::NP_SETS; s++) begin : g_np
    localparam bit EXISTS = (s == 0) || OAM_ENGINE;
    localparam logic [ehc_pkg::ADDR_W-1:0] CTRL_A =
      (s == 0) ? ehc_pkg::REG_NP_CTRL_A : ehc_pkg::REG_NP_CTRL_B;
    localparam logic [ehc_pkg::ADDR_W-1:0] ETYPE_A =
      (s == 0) ? ehc_pkg::REG_NP_ETYPE_A : ehc_pkg::REG_NP_ETYPE_B;
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        np_ff[s] <= '0;
      end else if (EXISTS && reg_wr_i) begin
        if (reg_addr_i == CTRL_A) begin
          np_ff[s].ctrl <= np_ctrl_w;
          if (np_ctrl_w.next_stage > ehc_pkg::LAST_STAGE_ID) begin
            np_ff[s].ctrl.next_stage <= np_ff[s].ctrl.next_stage;
          end
        end
        if (reg_addr_i == ETYPE_A) begin
          np_ff[s].etype <= reg_wdata_i[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      global_ff <= '0;
    end else if (reg_wr_i && (reg_addr_i == ehc_pkg::REG_GLOBAL)) begin
      global_ff <= ehc_pkg::ehc_global_s'(reg_wdata_i &
                   (FIRST_STAGE ? ehc_pkg::GLOBAL_WMASK : ehc_pkg::GLOBAL_WMASK_NB));
    end
  end

  for (genvar f = 0; f < FLOWS; f++) begin : g_flow_reg
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        flow_ff[f] <= '0;
      end else if (reg_wr_i && flow_page && (int'(flow_idx) == f)) begin
        unique case (flow_sub)
          ehc_pkg::FL_CTRL: begin
            flow_ff[f].ctrl <= ehc_pkg::ehc_flow_ctrl_s'(reg_wdata_i & ehc_pkg::FL_CTRL_WMASK);
          end
          ehc_pkg::FL_ADDR_LO: begin
            flow_ff[f].addr[31:0] <= reg_wdata_i;
          end
          ehc_pkg::FL_ADDR_HI: begin
            flow_ff[f].addr[47:32] <= reg_wdata_i[15:0];
          end
          ehc_pkg::FL_TAG1: begin
            flow_ff[f].tag1 <= ehc_pkg::ehc_pair12_s'(reg_wdata_i & ehc_pkg::TAG_WMASK);
          end
          ehc_pkg::FL_TAG2: begin
            flow_ff[f].tag2 <= ehc_pkg::ehc_pair12_s'(reg_wdata_i & ehc_pkg::TAG_WMASK);
          end
          ehc_pkg::FL_RANGE: begin
            flow_ff[f].rng <= ehc_pkg::ehc_pair12_s'(reg_wdata_i & ehc_pkg::TAG_WMASK);
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    rd_val = '0;
    if (reg_addr_i == ehc_pkg::REG_NP_CTRL_A) begin
      rd_val = np_ff[0].ctrl;
    end else if (reg_addr_i == ehc_pkg::REG_NP_ETYPE_A) begin
      rd_val = ehc_pkg::DATA_W'(np_ff[0].etype);
    end else if (OAM_ENGINE && (reg_addr_i == ehc_pkg::REG_NP_CTRL_B)) begin
      rd_val = np_ff[1].ctrl;
    end else if (OAM_ENGINE && (reg_addr_i == ehc_pkg::REG_NP_ETYPE_B)) begin
      rd_val = ehc_pkg::DATA_W'(np_ff[1].etype);
    end else if (reg_addr_i == ehc_pkg::REG_GLOBAL) begin
      rd_val = global_ff;
    end else if (reg_addr_i == ehc_pkg::REG_STATUS) begin
      rd_val = {11'h000, res_ff.sig_offset, 4'h0, res_ff.next_stage, res_ff.hit, res_ff.flows};
    end else if (flow_page && (int'(flow_idx) < FLOWS)) begin
      unique case (flow_sub)
        ehc_pkg::FL_CTRL:    rd_val = flow_ff[flow_idx].ctrl;
        ehc_pkg::FL_ADDR_LO: rd_val = flow_ff[flow_idx].addr[31:0];
        ehc_pkg::FL_ADDR_HI: rd_val = ehc_pkg::DATA_W'(flow_ff[flow_idx].addr[47:32]);
        ehc_pkg::FL_TAG1:    rd_val = flow_ff[flow_idx].tag1;
        ehc_pkg::FL_TAG2:    rd_val = flow_ff[flow_idx].tag2;
        ehc_pkg::FL_RANGE:   rd_val = flow_ff[flow_idx].rng;
        default:             rd_val = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= '0;
    end else if (reg_rd_i) begin
      rdata_ff <= rd_val;
    end else begin
      rdata_ff <= '0;
    end
  end

  // Header capture: a frame start restarts capture unless the decode cycle is running.
  assign start_w   = frm_valid_i && frm_i.sof && (state_ff != ehc_pkg::EHC_DECODE);
  assign cap_en    = start_w || (frm_valid_i && (state_ff == ehc_pkg::EHC_CAPTURE));
  assign wr_idx    = start_w ? '0 : cnt_ff;
  assign last_byte = frm_i.eof || (wr_idx == CNT_W'(HDR_BYTES - 1));

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= ehc_pkg::EHC_IDLE;
    end else begin
      unique case (state_ff)
        ehc_pkg::EHC_IDLE,
        ehc_pkg::EHC_CAPTURE: begin
          if (cap_en) begin
            state_ff <= last_byte ? ehc_pkg::EHC_DECODE : ehc_pkg::EHC_CAPTURE;
          end
        end
        ehc_pkg::EHC_DECODE: state_ff <= ehc_pkg::EHC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff  <= '0;
      chan_ff <= '0;
    end else begin
      if (cap_en) begin
        cnt_ff <= CNT_W'(wr_idx + 1'b1);
      end
      if (start_w) begin
        chan_ff <= frm_i.chan;
      end
    end
  end

  for (genvar b = 0; b < HDR_BYTES; b++) begin : g_hdr
    always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
        hdr_ff[b] <= '0;
      end else if (cap_en && (int'(wr_idx) == b)) begin
        hdr_ff[b] <= frm_i.data;
      end else if (start_w) begin
        hdr_ff[b] <= '0;
      end
    end
  end

  // Header decode from the captured bytes.
  always_comb begin
    hdr     = '0;
    w_t0    = wrd(ehc_pkg::OFS_TAG);
    w_t1tci = wrd(ehc_pkg::OFS_TAG + ehc_pkg::OFS_TCI);
    w_t1w   = wrd(ehc_pkg::OFS_TAG + ehc_pkg::TAG_LEN);
    w_t2tci = wrd(ehc_pkg::OFS_TAG + ehc_pkg::TAG_LEN + ehc_pkg::OFS_TCI);
    i_off   = ehc_pkg::OFS_TAG;
    e_off   = ehc_pkg::OFS_TAG;
    w_tl    = '0;
    for (int k = 0; k < ehc_pkg::ADDR_BYTES; k++) begin
      hdr.da[47 - 8 * k -: 8] = hdr_ff[ehc_pkg::OFS_DA + k];
      hdr.sa[47 - 8 * k -: 8] = hdr_ff[ehc_pkg::OFS_SA + k];
    end
    hdr.tag1_tpid = w_t0;
    hdr.tag1_vid  = w_t1tci[11:0];
    if (pbb_on) begin
      hdr.btag       = w_t0 == global_ff.tpid;
      i_off          = hdr.btag ? ehc_pkg::OFS_TAG + ehc_pkg::TAG_LEN : ehc_pkg::OFS_TAG;
      hdr.ntags      = hdr.btag ? 2'h2 : 2'h1;
      hdr.itag_ok    = wrd(i_off) == ehc_pkg::I_TAG_TPID;
      hdr.isid       = {hdr_ff[i_off + ehc_pkg::OFS_ISID], hdr_ff[i_off + ehc_pkg::OFS_ISID + 1],
                        hdr_ff[i_off + ehc_pkg::OFS_ISID + 2]};
      hdr.last_etype = wrd(i_off);
    end else begin
      hdr.tag2_tpid = w_t1w;
      hdr.tag2_vid  = w_t2tci[11:0];
      if (is_tag(w_t0, global_ff.tpid)) begin
        hdr.ntags = is_tag(w_t1w, global_ff.tpid) ? 2'h2 : 2'h1;
      end
      e_off      = ehc_pkg::OFS_TAG + ehc_pkg::TAG_LEN * int'(hdr.ntags);
      w_tl       = wrd(e_off);
      hdr.is_len = w_tl < ehc_pkg::LEN_LIMIT;
      hdr.llc_ok = ((hdr_ff[e_off + ehc_pkg::OFS_DSAP] == ehc_pkg::LLC_SAP_A) ||
                    (hdr_ff[e_off + ehc_pkg::OFS_DSAP] == ehc_pkg::LLC_SAP_B)) &&
                   ((hdr_ff[e_off + ehc_pkg::OFS_SSAP] == ehc_pkg::LLC_SAP_A) ||
                    (hdr_ff[e_off + ehc_pkg::OFS_SSAP] == ehc_pkg::LLC_SAP_B)) &&
                   (hdr_ff[e_off + ehc_pkg::OFS_CTL] == ehc_pkg::LLC_CTL) &&
                   (({hdr_ff[e_off + ehc_pkg::OFS_OUI], hdr_ff[e_off + ehc_pkg::OFS_OUI + 1],
                      hdr_ff[e_off + ehc_pkg::OFS_OUI + 2]} == ehc_pkg::OUI_ZERO) ||
                    ({hdr_ff[e_off + ehc_pkg::OFS_OUI], hdr_ff[e_off + ehc_pkg::OFS_OUI + 1],
                      hdr_ff[e_off + ehc_pkg::OFS_OUI + 2]} == ehc_pkg::OUI_ALT));
      hdr.last_etype = hdr.is_len ? wrd(e_off + ehc_pkg::OFS_SNAP_ET) : w_tl;
    end
  end

  always_comb begin
    for (int s = 0; s < ehc_pkg::NP_SETS; s++) begin
      np_ok[s] = !np_ff[s].ctrl.etype_en || hdr.is_len ||
                 (hdr.last_etype == np_ff[s].etype);
    end
  end

  for (genvar f = 0; f < ehc_pkg::FLOWS_MAX; f++) begin : g_flow
    if (f < FLOWS) begin : g_used
      logic t1_eq;
      logic t2_eq;
      logic t1_rng;
      logic t2_rng;
      assign flow_set[f] = OAM_ENGINE && flow_ff[f].ctrl.grp_sel;
      ehc_tag_cmp #(
        .W(12)
      ) u_tag1 (
        .value_i    (hdr.tag1_vid),
        .match_i    (flow_ff[f].tag1.lo),
        .wildcard_i (flow_ff[f].tag1.hi),
        .low_i      (flow_ff[f].rng.lo),
        .high_i     (flow_ff[f].rng.hi),
        .eq_o       (t1_eq),
        .in_range_o (t1_rng)
      );
      ehc_tag_cmp #(
        .W(12)
      ) u_tag2 (
        .value_i    (hdr.tag2_vid),
        .match_i    (flow_ff[f].tag2.lo),
        .wildcard_i (flow_ff[f].tag2.hi),
        .low_i      (flow_ff[f].rng.lo),
        .high_i     (flow_ff[f].rng.hi),
        .eq_o       (t2_eq),
        .in_range_o (t2_rng)
      );
      ehc_flow_match u_match (
        .cfg_i    (flow_ff[f]),
        .hdr_i    (hdr),
        .tpid_i   (global_ff.tpid),
        .pbb_i    (pbb_on),
        .chan_i   (chan_ff),
        .np_ok_i  (np_ok[flow_set[f]]),
        .t1_eq_i  (t1_eq),
        .t2_eq_i  (t2_eq),
        .t1_rng_i (t1_rng),
        .t2_rng_i (t2_rng),
        .match_o  (flow_hit[f])
      );
    end else begin : g_unused
      assign flow_set[f] = 1'b0;
      assign flow_hit[f] = 1'b0;
    end
  end

  // The lowest-numbered hitting flow decides which set hands off.
  always_comb begin
    sel_set = 1'b0;
    for (int i = ehc_pkg::FLOWS_MAX - 1; i >= 0; i--) begin
      if (flow_hit[i]) begin
        sel_set = flow_set[i];
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      res_valid_ff <= 1'b0;
      res_ff       <= '0;
    end else begin
      res_valid_ff <= state_ff == ehc_pkg::EHC_DECODE;
      if (state_ff == ehc_pkg::EHC_DECODE) begin
        res_ff.hit        <= |flow_hit;
        res_ff.flows      <= flow_hit;
        res_ff.next_stage <= np_ff[sel_set].ctrl.next_stage;
        res_ff.sig_offset <= np_ff[sel_set].ctrl.sig_offset;
      end
    end
  end

  assign reg_rdata_o = rdata_ff;
  assign res_valid_o = res_valid_ff;
  assign res_o       = res_ff;

endmodule

`default_nettype wire

/* File: design/ehc_flow_match.sv */
`timescale 1ns/100ps
`default_nettype none

module ehc_flow_match (
  input  wire ehc_pkg::ehc_flow_cfg_s cfg_i,
  input  wire ehc_pkg::ehc_hdr_s      hdr_i,
  input  wire logic [15:0]            tpid_i,
  input  wire logic                   pbb_i,
  input  wire logic [2:0]             chan_i,
  input  wire logic                   np_ok_i,
  input  wire logic                   t1_eq_i,
  input  wire logic                   t2_eq_i,
  input  wire logic                   t1_rng_i,
  input  wire logic                   t2_rng_i,
  output logic                        match_o
);

  logic tags_ok;
  logic et_ok;
  logic addr_ok;
  logic type1_ok;
  logic type2_ok;
  logic rng_ok;

  function automatic logic addr_hit(input logic [47:0] a, input ehc_pkg::ehc_flow_cfg_s c);
    addr_hit = (c.ctrl.addr_mode[ehc_pkg::AM_FULL] && (a == c.addr)) ||
               (c.ctrl.addr_mode[ehc_pkg::AM_UNI] && !a[ehc_pkg::GROUP_BIT]) ||
               (c.ctrl.addr_mode[ehc_pkg::AM_MULTI] && a[ehc_pkg::GROUP_BIT]);
  endfunction

  always_comb begin
    type1_ok = hdr_i.tag1_tpid == (cfg_i.ctrl.t1_type ? tpid_i : ehc_pkg::C_TAG_TPID);
    type2_ok = hdr_i.tag2_tpid == (cfg_i.ctrl.t2_type ? tpid_i : ehc_pkg::C_TAG_TPID);
    rng_ok   = (cfg_i.ctrl.range_mode == ehc_pkg::RNG_TAG1) ? t1_rng_i :
               (cfg_i.ctrl.range_mode == ehc_pkg::RNG_TAG2) ? t2_rng_i : 1'b1;
    if (pbb_i) begin
      // The I-tag service identifier is checked even without tag verification.
      tags_ok = (cfg_i.ctrl.t1_type ? !hdr_i.btag : hdr_i.btag) && hdr_i.itag_ok &&
                (hdr_i.isid == {cfg_i.rng.hi, cfg_i.rng.lo}) &&
                (!cfg_i.ctrl.verify ||
                 ((cfg_i.ctrl.tag_count == hdr_i.ntags) && (cfg_i.ctrl.t1_type || t1_eq_i)));
    end else begin
      tags_ok = !cfg_i.ctrl.verify ||
                ((cfg_i.ctrl.tag_count == hdr_i.ntags) &&
                 ((hdr_i.ntags == 2'h0) || (type1_ok && t1_eq_i)) &&
                 ((hdr_i.ntags != 2'h2) || (type2_ok && t2_eq_i)) && rng_ok);
    end
    et_ok = cfg_i.ctrl.et_mode ? (!hdr_i.is_len || hdr_i.llc_ok) : !hdr_i.is_len;
    unique case (cfg_i.ctrl.addr_sel)
      ehc_pkg::SEL_DA:     addr_ok = addr_hit(hdr_i.da, cfg_i);
      ehc_pkg::SEL_SA:     addr_ok = addr_hit(hdr_i.sa, cfg_i);
      ehc_pkg::SEL_EITHER: addr_ok = addr_hit(hdr_i.da, cfg_i) || addr_hit(hdr_i.sa, cfg_i);
      default:             addr_ok = 1'b0;
    endcase
    match_o = cfg_i.ctrl.enable && cfg_i.ctrl.chan_mask[chan_i] && np_ok_i &&
              tags_ok && et_ok && addr_ok;
  end

endmodule

`default_nettype wire

/* File: design/ehc_pkg.sv */
package ehc_pkg;

  localparam int FLOWS_MAX     = 8;
  localparam int HDR_BYTES_MIN = 30;
  localparam int NP_SETS       = 2;
  localparam int ADDR_W        = 12;
  localparam int DATA_W        = 32;
  localparam int STAGE_W       = 3;

  localparam logic [STAGE_W-1:0] LAST_STAGE_ID = 3'h5;

  localparam logic [15:0] C_TAG_TPID = 16'h8100;
  localparam logic [15:0] I_TAG_TPID = 16'h88E7;
  localparam logic [15:0] LEN_LIMIT  = 16'h0600;
  localparam logic [7:0]  LLC_SAP_A  = 8'hAA;
  localparam logic [7:0]  LLC_SAP_B  = 8'hAB;
  localparam logic [7:0]  LLC_CTL    = 8'h03;
  localparam logic [23:0] OUI_ZERO   = 24'h000000;
  localparam logic [23:0] OUI_ALT    = 24'h0000F8;

  // Byte positions inside the captured header.
  localparam int OFS_DA      = 0;
  localparam int OFS_SA      = 6;
  localparam int ADDR_BYTES  = 6;
  localparam int OFS_TAG     = 12;
  localparam int TAG_LEN     = 4;
  localparam int OFS_TCI     = 2;
  localparam int OFS_DSAP    = 2;
  localparam int OFS_SSAP    = 3;
  localparam int OFS_CTL     = 4;
  localparam int OFS_OUI     = 5;
  localparam int OFS_SNAP_ET = 8;
  localparam int OFS_ISID    = 3;
  localparam int GROUP_BIT   = 40;

  localparam int AM_FULL  = 0;
  localparam int AM_UNI   = 1;
  localparam int AM_MULTI = 2;

  localparam logic [1:0] SEL_DA     = 2'h0;
  localparam logic [1:0] SEL_SA     = 2'h1;
  localparam logic [1:0] SEL_EITHER = 2'h2;
  localparam logic [1:0] RNG_TAG1   = 2'h1;
  localparam logic [1:0] RNG_TAG2   = 2'h2;

  localparam logic [ADDR_W-1:0] REG_NP_CTRL_A  = 12'h000;
  localparam logic [ADDR_W-1:0] REG_NP_ETYPE_A = 12'h004;
  localparam logic [ADDR_W-1:0] REG_NP_CTRL_B  = 12'h010;
  localparam logic [ADDR_W-1:0] REG_NP_ETYPE_B = 12'h014;
  localparam logic [ADDR_W-1:0] REG_GLOBAL     = 12'h020;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 12'h024;
  localparam logic [3:0]        FLOW_PAGE      = 4'h1;
  localparam logic [4:0]        FL_CTRL        = 5'h00;
  localparam logic [4:0]        FL_ADDR_LO     = 5'h04;
  localparam logic [4:0]        FL_ADDR_HI     = 5'h08;
  localparam logic [4:0]        FL_TAG1        = 5'h0C;
  localparam logic [4:0]        FL_TAG2        = 5'h10;
  localparam logic [4:0]        FL_RANGE       = 5'h14;

  localparam logic [DATA_W-1:0] NP_CTRL_WMASK   = 32'h00011F07;
  localparam logic [DATA_W-1:0] GLOBAL_WMASK    = 32'h0001FFFF;
  localparam logic [DATA_W-1:0] GLOBAL_WMASK_NB = 32'h0000FFFF;
  localparam logic [DATA_W-1:0] FL_CTRL_WMASK   = 32'h03FFFFF1;
  localparam logic [DATA_W-1:0] TAG_WMASK       = 32'h0FFF0FFF;

  typedef enum logic [1:0] {
    EHC_IDLE,
    EHC_CAPTURE,
    EHC_DECODE
  } ehc_state_e;

  typedef struct packed {
    logic [14:0] pad_hi;
    logic        etype_en;
    logic [2:0]  pad_mid;
    logic [4:0]  sig_offset;
    logic [4:0]  pad_lo;
    logic [2:0]  next_stage;
  } ehc_np_ctrl_s;

  typedef struct packed {
    ehc_np_ctrl_s ctrl;
    logic [15:0]  etype;
  } ehc_np_cfg_s;

  typedef struct packed {
    logic [14:0] pad;
    logic        pbb_en;
    logic [15:0] tpid;
  } ehc_global_s;

  typedef struct packed {
    logic [5:0] pad_hi;
    logic       grp_sel;
    logic [2:0] addr_mode;
    logic [1:0] addr_sel;
    logic [1:0] range_mode;
    logic       verify;
    logic       et_mode;
    logic       t2_type;
    logic       t1_type;
    logic [1:0] tag_count;
    logic [7:0] chan_mask;
    logic [2:0] pad_lo;
    logic       enable;
  } ehc_flow_ctrl_s;

  typedef struct packed {
    logic [3:0]  pad_hi;
    logic [11:0] hi;
    logic [3:0]  pad_lo;
    logic [11:0] lo;
  } ehc_pair12_s;

  typedef struct packed {
    ehc_flow_ctrl_s ctrl;
    logic [47:0]    addr;
    ehc_pair12_s    tag1;
    ehc_pair12_s    tag2;
    ehc_pair12_s    rng;
  } ehc_flow_cfg_s;

  typedef struct packed {
    logic       sof;
    logic       eof;
    logic [2:0] chan;
    logic [7:0] data;
  } ehc_byte_s;

  typedef struct packed {
    logic [47:0] da;
    logic [47:0] sa;
    logic [1:0]  ntags;
    logic [15:0] tag1_tpid;
    logic [15:0] tag2_tpid;
    logic [11:0] tag1_vid;
    logic [11:0] tag2_vid;
    logic        btag;
    logic        itag_ok;
    logic [23:0] isid;
    logic        is_len;
    logic        llc_ok;
    logic [15:0] last_etype;
  } ehc_hdr_s;

  typedef struct packed {
    logic                 hit;
    logic [FLOWS_MAX-1:0] flows;
    logic [STAGE_W-1:0]   next_stage;
    logic [4:0]           sig_offset;
  } ehc_result_s;

endpackage

/* File: design/ehc_tag_cmp.sv */
`timescale 1ns/100ps
`default_nettype none

module ehc_tag_cmp #(
  parameter int W = 12
) (
  input  wire logic [W-1:0] value_i,
  input  wire logic [W-1:0] match_i,
  input  wire logic [W-1:0] wildcard_i,
  input  wire logic [W-1:0] low_i,
  input  wire logic [W-1:0] high_i,
  output logic              eq_o,
  output logic              in_range_o
);

  assign eq_o       = ((value_i ^ match_i) & wildcard_i) == '0;
  assign in_range_o = (value_i >= low_i) && (value_i <= high_i);

endmodule

`default_nettype wire

/* File: verification/ehc_comparator_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module ehc_comparator_checker (
  input wire logic                       clk_i,
  input wire logic                       rst_i,
  input wire logic [ehc_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [ehc_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic                       reg_wr_i,
  input wire logic                       reg_rd_i,
  input wire logic [ehc_pkg::DATA_W-1:0] reg_rdata_o,
  input wire logic                       frm_valid_i,
  input wire ehc_pkg::ehc_byte_s         frm_i,
  input wire logic                       res_valid_o,
  input wire ehc_pkg::ehc_result_s       res_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_rdata_idle: assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0)
    else $error("read data not idle");
  a_unmapped_zero: assert property (reg_rd_i && reg_addr_i == 12'hFFC |=> reg_rdata_o == '0)
    else $error("unmapped read not zero");
  a_result_pulse: assert property (res_valid_o |=> !res_valid_o)
    else $error("result pulse too long");
  a_result_hold: assert property (!res_valid_o |-> $stable(res_o))
    else $error("result changed without pulse");
  a_eof_latency: assert property (frm_valid_i && frm_i.eof |-> ##2 res_valid_o)
    else $error("result late after last byte");
  a_no_spurious: assert property (res_valid_o |-> $past(frm_valid_i, 2))
    else $error("result without frame");
  a_stage_legal: assert property (
    res_valid_o |-> res_o.next_stage <= ehc_pkg::LAST_STAGE_ID)
    else $error("next stage out of range");
  a_hit_flows: assert property (res_valid_o |-> res_o.hit == (|res_o.flows))
    else $error("hit and flows disagree");
  c_hit: cover property (res_valid_o && res_o.hit);
  c_miss: cover property (res_valid_o && !res_o.hit);
  c_read: cover property (reg_rd_i ##1 reg_rdata_o != '0);
endmodule
bind ehc_comparator ehc_comparator_checker chk (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i,
  .reg_wr_i, .reg_rd_i, .reg_rdata_o, .frm_valid_i, .frm_i, .res_valid_o, .res_o);
`default_nettype wire

/* File: verification/ehc_comparator_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module ehc_comparator_tb_top;
  logic                   clk_i = 1'b0;
  logic                   rst_i = 1'b1;
  logic [11:0]            reg_addr_i = '0;
  logic [31:0]            reg_wdata_i = '0;
  logic                   reg_wr_i = 1'b0;
  logic                   reg_rd_i = 1'b0;
  logic [31:0]            reg_rdata_o;
  logic                   frm_valid_i;
  ehc_pkg::ehc_byte_s     frm_i;
  logic                   res_valid_o;
  ehc_pkg::ehc_result_s   res_o;
  int                     miscompares = 0;
  int                     total_checks = 0;
  localparam logic [47:0] DA = 48'h021122334455;
  localparam logic [47:0] SA = 48'h0A0B0C0D0E0F;
  localparam logic [16:0] HIT = 17'h1017F;
  localparam logic [16:0] MISS = 17'h0007F;
  localparam logic [255:0] LLC = {DA, SA, 16'h0010, 48'hAAAA03000000, 96'h0};
  always #50 clk_i = ~clk_i;
  ehc_comparator uut (.clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .frm_valid_i, .frm_i, .res_valid_o, .res_o);
  ehc_frame_src src (.clk_i, .frm_valid_o(frm_valid_i), .frm_o(frm_i));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk(reg_rdata_o, e);
  endtask
  task automatic fr(input logic [255:0] h, input logic [2:0] ch, input logic [16:0] e);
    int n;
    src.send(h, 20, ch);
    n = 0;
    while (res_valid_o !== 1'b1 && n < 10) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (res_valid_o !== 1'b1) begin
      miscompares++;
      $display("[ERR] %0t no result", $time);
      wrap_up;
    end
    chk({15'h0, res_o}, {15'h0, e});
    repeat (2) @(posedge clk_i);
  endtask
  task automatic t_regs;
    wr(12'h020, 32'h000188A8);
    rd(12'h020, 32'h000188A8);
    wr(12'h020, 32'h000088A8);
    wr(12'h000, 32'h00011F03);
    wr(12'h000, 32'h00011F07);
    rd(12'h000, 32'h00011F03);
    wr(12'h004, 32'h000088F7);
    rd(12'hFFC, 32'h00000000);
    $display("test regs done");
  endtask
  task automatic t_np;
    wr(12'h100, 32'h00420011);
    wr(12'h104, DA[31:0]);
    wr(12'h108, {16'h0, DA[47:32]});
    fr({DA, SA, 16'h88F7, 144'h0}, 3'h0, HIT);
    fr({DA, SA, 16'h0800, 144'h0}, 3'h0, MISS);
    fr({DA, SA, 16'h88F7, 144'h0}, 3'h1, MISS);
    fr(LLC, 3'h0, MISS);
    wr(12'h100, 32'h00430011);
    fr(LLC, 3'h0, HIT);
    $display("test next protocol done");
  endtask
  task automatic t_addr;
    wr(12'h100, 32'h01020011);
    fr({DA, SA, 16'h88F7, 144'h0}, 3'h0, MISS);
    fr({48'h011122334455, SA, 16'h88F7, 144'h0}, 3'h0, HIT);
    wr(12'h100, 32'h00620011);
    fr({SA, DA, 16'h88F7, 144'h0}, 3'h0, HIT);
    wr(12'h100, 32'h00920011);
    fr({48'h011122334455, SA, 16'h88F7, 144'h0}, 3'h0, HIT);
    $display("test address done");
  endtask
  task automatic t_tag;
    wr(12'h100, 32'h00461011);
    wr(12'h10C, 32'h0FFF0123);
    wr(12'h114, 32'h01230123);
    fr({DA, SA, 16'h8100, 16'h0123, 16'h88F7, 112'h0}, 3'h0, HIT);
    wr(12'h10C, 32'h0FF00123);
    fr({DA, SA, 16'h8100, 16'h0124, 16'h88F7, 112'h0}, 3'h0, MISS);
    wr(12'h114, 32'h012F0123);
    fr({DA, SA, 16'h8100, 16'h0124, 16'h88F7, 112'h0}, 3'h0, HIT);
    $display("test tags done");
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs;
    t_np;
    t_addr;
    t_tag;
    wrap_up;
  end
endmodule
`default_nettype wire

/* File: verification/ehc_frame_src.sv */
`timescale 1ns/100ps
`default_nettype none
module ehc_frame_src (
  input  wire logic          clk_i,
  output logic               frm_valid_o,
  output ehc_pkg::ehc_byte_s frm_o
);
  initial begin
    frm_valid_o = 1'b0;
    frm_o = '0;
  end
  // Bytes leave in wire order, and the line shows the inverted last byte once released.
  task automatic send(input logic [255:0] h, input int n, input logic [2:0] ch);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      frm_valid_o <= 1'b1;
      frm_o <= {i == 0, i == n - 1, ch, h[255-8*i -: 8]};
    end
    @(posedge clk_i);
    frm_valid_o <= 1'b0;
    frm_o <= {2'h0, ~frm_o.chan, ~frm_o.data};
  endtask
endmodule
`default_nettype wire
